// file: hdl/qtc_pkg.sv
// constants for the quad 8-bit timer/counter block
package qtc_pkg;

  localparam int ADDR_W = 12;
  localparam int PRE_W = 12;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_T02_FIRST_MODE = 8'hD0;
  localparam logic [7:0] IDX_T0_VIEW = 8'hD1;
  localparam logic [7:0] IDX_T13_FIRST_MODE = 8'hD2;
  localparam logic [7:0] IDX_T1_CMP = 8'hD3;
  localparam logic [7:0] IDX_T1_VIEW = 8'hD4;
  localparam logic [7:0] IDX_T02_SECOND_MODE = 8'hD6;
  localparam logic [7:0] IDX_T2_VIEW = 8'hD7;
  localparam logic [7:0] IDX_T13_SECOND_MODE = 8'hD8;
  localparam logic [7:0] IDX_T3_CMP = 8'hD9;
  localparam logic [7:0] IDX_T3_VIEW = 8'hDA;
  localparam logic [7:0] IDX_MATCH_FLAGS = 8'hDC;
  localparam logic [7:0] IDX_CAPTURE_EDGE = 8'hDD;

  // mode register fields
  localparam int B_ST = 0;
  localparam int B_CN = 1;
  localparam int B_CK = 2;
  localparam int B_CAP = 5;
  localparam int B_PWMEN = 5;
  localparam int B_WIDE = 6;
  localparam int B_POL = 7;

  // writable bits of the mode registers
  localparam logic [7:0] MASK_T02_MODE = 8'h3F;
  localparam logic [7:0] MASK_T1_MODE = 8'h4F;
  localparam logic [7:0] MASK_T3_MODE = 8'hEF;
  localparam logic [3:0] MASK_FLAGS = 4'hF;

  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CMP = 8'hFF;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [3:0] RST_EDGE = 4'h5;
  localparam logic [7:0] CNT_ALL_ONES = 8'hFF;

  localparam logic [2:0] CK02_PIN = 3'h7;
  localparam logic [1:0] CK13_CHAIN = 2'h3;

  // prescaler exponents, divide by 2**n, indexed by clock select code
  localparam logic [6:0][3:0] EXP_T0 = {4'hB, 4'h9, 4'h7, 4'h5, 4'h3, 4'h2, 4'h1};
  localparam logic [6:0][3:0] EXP_T2 = {4'hC, 4'hA, 4'h8, 4'h6, 4'h4, 4'h2, 4'h1};
  localparam logic [2:0][3:0] EXP_T1 = {4'h3, 4'h1, 4'h0};
  localparam logic [2:0][3:0] EXP_T3 = {4'h4, 4'h1, 4'h0};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hdl/qtc_prescaler.sv
// free-running prescaler giving one-cycle ticks at main clock divided by 2**k
`timescale 1ns/1ps
module qtc_prescaler #(
  parameter int PRE_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic [PRE_W:0] tick
);

  typedef struct packed {
    logic [PRE_W-1:0] div;
  } qtc_pre_state_t;

  qtc_pre_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + {{(PRE_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // tick[k] fires once every 2**k cycles; tick[0] every cycle
  always_comb begin
    tick[0] = 1'b1;
    for (int k = 1; k <= PRE_W; k++) begin
      tick[k] = &(s_q.div | ~((PRE_W'(1) << k) - PRE_W'(1)));
    end
  end

endmodule // qtc_prescaler

// file: hdl/qtc_counter.sv
// one 8-bit count register with its capture register
`timescale 1ns/1ps
module qtc_counter #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic cap_evt,
  input wire logic inc,
  input wire logic wrap,
  output logic [W-1:0] cnt,
  output logic [W-1:0] cap
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] cap;
  } qtc_cnt_state_t;

  qtc_cnt_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.cnt = '0;
    end else if (cap_evt) begin
      s_d.cap = s_q.cnt;
      s_d.cnt = '0;
    end else if (inc) begin
      if (wrap) begin
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cnt = s_q.cnt;
  assign cap = s_q.cap;

endmodule // qtc_counter

// file: hdl/qtc_top.sv
// quad 8-bit timer/counter with AXI4-Lite register access
`timescale 1ns/1ps
// Functional notes
// - five modes: timer, capture, compare, wide, PWM
// - timer 0 counts prescaled clock, 1/2..1/2048
// - timer 1 adds fast sources 1/1..1/8
// - event counter advances on pin rising edge
// - capture edge copies count into capture register
// - timer 3 feeds PWM, timer 2 compare output
// - capture bit: 0 timer, 1 capture
// - timers 0/2 continue bit pauses counting
// - timers 0/2 start bit stops or restarts
// - 3-bit clock select tables, timer 0 pin
// - wide bit pairs timers into 16 bits
// - polarity bit sets PWM duty level
// - PWM enable picks PWM or compare output
// - 2-bit clock select tables, code 11 chains
// - timers 1/3 continue bit stops counting unless the pair is wide
// - timers 1/3 start bit restarts, and stops unless the pair is wide
// - clear only on start bit rising
// - count and capture share read address
// - shared address reads view, writes compare on timers 0/2, duty on timer 3
// - count to compare, wrap, set flag
// - capture clears and restarts the counter
// - wide match flags the lower timer only
module qtc_top
  import qtc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic EVENT_COUNT_INPUT,
  input wire logic [1:0] CAPTURE_INPUT,
  output logic TIMER_OUT_PIN,
  output logic [3:0] TIMER_MATCH_FLAG
);

  typedef struct packed {
    logic aw_v;
    logic [ADDR_W-1:0] aw_a;
    logic w_v;
    logic [7:0] w_d;
    logic w_s;
    logic b_v;
    logic [1:0] b_r;
    logic r_v;
    logic [7:0] r_d;
    logic [1:0] r_r;
    logic [3:0][7:0] mode;
    logic [3:0][7:0] cmp;
    logic [7:0] duty;
    logic [3:0] flag;
    logic [3:0] esel;
    logic [3:0] clr;
    logic ec_s1;
    logic ec_s2;
    logic ec_s3;
    logic [1:0] cp_s1;
    logic [1:0] cp_s2;
    logic [1:0] cp_s3;
    logic t2o;
    logic pin;
  } qtc_top_state_t;

  qtc_top_state_t s_q, s_d;

  logic [PRE_W:0] pre_tick;
  logic [3:0][7:0] cnt;
  logic [3:0][7:0] cap;
  logic [3:0] run, inc, wrap, clr_u, cap_evt, tick_src, set_flag;
  logic [1:0] wide, match16, cap_edge;
  logic [3:0] match8;
  logic ec_rise;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counters

  qtc_prescaler #(
    .PRE_W(PRE_W)
  ) u_pre (
    .clk(CLOCK),
    .rst_n(RESETN),
    .tick(pre_tick)
  );

  for (genvar i = 0; i < 4; i++) begin : g_cnt
    qtc_counter #(
      .W(8)
    ) u_cnt (
      .clk(CLOCK),
      .rst_n(RESETN),
      .clr(clr_u[i]),
      .cap_evt(cap_evt[i]),
      .inc(inc[i]),
      .wrap(wrap[i]),
      .cnt(cnt[i]),
      .cap(cap[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock sources and counting control

  assign ec_rise = s_q.ec_s2 & ~s_q.ec_s3;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cap_edge[c] = (s_q.esel[2*c] & s_q.cp_s2[c] & ~s_q.cp_s3[c])
                  | (s_q.esel[2*c+1] & ~s_q.cp_s2[c] & s_q.cp_s3[c]);
    end
    // timer 0: prescaler or event pin
    if (s_q.mode[0][B_CK+:3] == CK02_PIN) begin
      tick_src[0] = ec_rise;
    end else begin
      tick_src[0] = pre_tick[EXP_T0[s_q.mode[0][B_CK+:3]]];
    end
    // timer 2: code 111 gives no clock
    if (s_q.mode[2][B_CK+:3] == CK02_PIN) begin
      tick_src[2] = 1'b0;
    end else begin
      tick_src[2] = pre_tick[EXP_T2[s_q.mode[2][B_CK+:3]]];
    end
    if (s_q.mode[1][B_CK+:2] == CK13_CHAIN) begin
      tick_src[1] = tick_src[0];
    end else begin
      tick_src[1] = pre_tick[EXP_T1[s_q.mode[1][B_CK+:2]]];
    end
    if (s_q.mode[3][B_CK+:2] == CK13_CHAIN) begin
      tick_src[3] = tick_src[2];
    end else begin
      tick_src[3] = pre_tick[EXP_T3[s_q.mode[3][B_CK+:2]]];
    end
    for (int i = 0; i < 4; i++) begin
      run[i] = s_q.mode[i][B_ST] & s_q.mode[i][B_CN];
      match8[i] = cnt[i] == s_q.cmp[i];
    end
    for (int p = 0; p < 2; p++) begin
      wide[p] = s_q.mode[2*p+1][B_WIDE];
      match16[p] = {cnt[2*p+1], cnt[2*p]} == {s_q.cmp[2*p+1], s_q.cmp[2*p]};
      inc[2*p] = run[2*p] & tick_src[2*p];
      wrap[2*p] = wide[p] ? match16[p] : match8[2*p];
      cap_evt[2*p] = s_q.mode[2*p][B_CAP] & cap_edge[p];
      clr_u[2*p] = s_q.clr[2*p] | (wide[p] & s_q.clr[2*p+1]);
      if (wide[p]) begin
        // upper byte advances on the lower byte's carry
        inc[2*p+1] = inc[2*p] & (match16[p] | (cnt[2*p] == CNT_ALL_ONES));
        wrap[2*p+1] = match16[p];
        cap_evt[2*p+1] = cap_evt[2*p];
        clr_u[2*p+1] = s_q.clr[2*p+1] | s_q.clr[2*p];
      end else begin
        inc[2*p+1] = run[2*p+1] & tick_src[2*p+1];
        wrap[2*p+1] = match8[2*p+1];
        cap_evt[2*p+1] = 1'b0;
        clr_u[2*p+1] = s_q.clr[2*p+1];
      end
      set_flag[2*p] = inc[2*p] & wrap[2*p] & ~clr_u[2*p] & ~cap_evt[2*p];
      set_flag[2*p+1] = ~wide[p] & inc[2*p+1] & wrap[2*p+1] & ~clr_u[2*p+1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read view

  function automatic logic [9:0] qtc_read(input logic [7:0] idx, input qtc_top_state_t s,
                                          input logic [3:0][7:0] c, input logic [3:0][7:0] k);
    logic [7:0] d;
    logic ok;
    d = 8'h00;
    ok = 1'b1;
    case (idx)
      IDX_T02_FIRST_MODE: d = s.mode[0] & MASK_T02_MODE;
      IDX_T0_VIEW: d = s.mode[0][B_CAP] ? k[0] : c[0];
      IDX_T13_FIRST_MODE: d = s.mode[1] & MASK_T1_MODE;
      IDX_T1_CMP: d = 8'h00;
      IDX_T1_VIEW: d = s.mode[0][B_CAP] & s.mode[1][B_WIDE] ? k[1] : c[1];
      IDX_T02_SECOND_MODE: d = s.mode[2] & MASK_T02_MODE;
      IDX_T2_VIEW: d = s.mode[2][B_CAP] ? k[2] : c[2];
      IDX_T13_SECOND_MODE: d = s.mode[3] & MASK_T3_MODE;
      IDX_T3_CMP: d = 8'h00;
      IDX_T3_VIEW: d = s.mode[2][B_CAP] & s.mode[3][B_WIDE] ? k[3] : c[3];
      IDX_MATCH_FLAGS: d = {4'h0, s.flag};
      IDX_CAPTURE_EDGE: d = {4'h0, s.esel};
      default: ok = 1'b0;
    endcase
    return {ok, 1'b0, d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, register writes and outputs

  always_comb begin
    logic [9:0] rd;
    logic [7:0] widx;
    logic [7:0] wd;
    logic wok;
    logic pwm_act;
    rd = '0;
    widx = s_q.aw_a[9:2];
    wd = s_q.w_d;
    wok = 1'b1;
    pwm_act = 1'b0;
    s_d = s_q;
    s_d.clr = 4'h0;
    // pin synchronisers
    s_d.ec_s1 = EVENT_COUNT_INPUT;
    s_d.ec_s2 = s_q.ec_s1;
    s_d.ec_s3 = s_q.ec_s2;
    s_d.cp_s1 = CAPTURE_INPUT;
    s_d.cp_s2 = s_q.cp_s1;
    s_d.cp_s3 = s_q.cp_s2;
    // write channel
    if (S_AXI_AWVALID && !s_q.aw_v) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_q.w_v) begin
      s_d.w_v = 1'b1;
      s_d.w_d = S_AXI_WDATA[7:0];
      s_d.w_s = S_AXI_WSTRB[0];
    end
    if (s_q.b_v && S_AXI_BREADY) begin
      s_d.b_v = 1'b0;
    end
    if (s_q.aw_v && s_q.w_v && !s_q.b_v) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.b_v = 1'b1;
      case (widx)
        IDX_T02_FIRST_MODE, IDX_T13_FIRST_MODE, IDX_T02_SECOND_MODE,
        IDX_T13_SECOND_MODE: begin
          if (s_q.w_s) begin
            for (int i = 0; i < 4; i++) begin
              if (widx == IDX_T02_FIRST_MODE + 8'(2 * i + (i / 2) * 2)) begin
                s_d.mode[i] = wd & (i == 1 ? MASK_T1_MODE :
                                    i == 3 ? MASK_T3_MODE : MASK_T02_MODE);
                s_d.clr[i] = wd[B_ST] & ~s_q.mode[i][B_ST];
              end
            end
          end
        end
        IDX_T0_VIEW: if (s_q.w_s) s_d.cmp[0] = wd;
        IDX_T1_CMP: if (s_q.w_s) s_d.cmp[1] = wd;
        IDX_T2_VIEW: if (s_q.w_s) s_d.cmp[2] = wd;
        IDX_T3_CMP: if (s_q.w_s) s_d.cmp[3] = wd;
        IDX_T3_VIEW: if (s_q.w_s) s_d.duty = wd;
        IDX_T1_VIEW: ;
        IDX_MATCH_FLAGS: if (s_q.w_s) s_d.flag = s_q.flag & ~(wd[3:0] & MASK_FLAGS);
        IDX_CAPTURE_EDGE: if (s_q.w_s) s_d.esel = wd[3:0];
        default: wok = 1'b0;
      endcase
      s_d.b_r = wok ? RESP_OKAY : RESP_SLVERR;
    end
    // read channel
    if (s_q.r_v && S_AXI_RREADY) begin
      s_d.r_v = 1'b0;
    end
    if (S_AXI_ARVALID && !s_q.r_v) begin
      rd = qtc_read(S_AXI_ARADDR[9:2], s_q, cnt, cap);
      s_d.r_v = 1'b1;
      s_d.r_d = rd[7:0];
      s_d.r_r = rd[9] ? RESP_OKAY : RESP_SLVERR;
    end
    // match flags: a new match beats a clear in the same cycle
    s_d.flag = s_d.flag | set_flag;
    // compare output toggles on each timer 2 match
    if (set_flag[2]) begin
      s_d.t2o = ~s_q.t2o;
    end
    pwm_act = cnt[3] < s_q.duty;
    if (s_q.mode[3][B_PWMEN]) begin
      s_d.pin = s_q.mode[3][B_POL] ? pwm_act : ~pwm_act;
    end else begin
      s_d.pin = s_q.t2o;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
      s_q.mode <= {4{RST_MODE}};
      s_q.cmp <= {4{RST_CMP}};
      s_q.duty <= RST_DUTY;
      s_q.esel <= RST_EDGE;
    end else begin
      s_q <= s_d;
    end
  end

  assign S_AXI_AWREADY = ~s_q.aw_v;
  assign S_AXI_WREADY = ~s_q.w_v;
  assign S_AXI_BVALID = s_q.b_v;
  assign S_AXI_BRESP = s_q.b_r;
  assign S_AXI_ARREADY = ~s_q.r_v;
  assign S_AXI_RVALID = s_q.r_v;
  assign S_AXI_RDATA = {24'h00_0000, s_q.r_d};
  assign S_AXI_RRESP = s_q.r_r;
  assign TIMER_OUT_PIN = s_q.pin;
  assign TIMER_MATCH_FLAG = s_q.flag;

endmodule // qtc_top

// file: tb/qtc_chk.sv
// port checker for the quad timer/counter block
`timescale 1ns/1ps
module qtc_chk
  import qtc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] TIMER_MATCH_FLAG
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  a_read_once: assert property (
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  a_byte_lane: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write not answered");
  a_flag_clear: assert property (
    |($past(TIMER_MATCH_FLAG) & ~TIMER_MATCH_FLAG) |-> S_AXI_BVALID)
    else $error("match flag dropped without write");
  a_bresp_code: assert property (
    S_AXI_BVALID |-> S_AXI_BRESP == RESP_OKAY || S_AXI_BRESP == RESP_SLVERR)
    else $error("illegal write response");
endmodule // qtc_chk

bind qtc_top qtc_chk qtc_chk_i (.*);

// file: tb/qtc_pin_model.sv
// far-side pins: event count input and capture inputs
`timescale 1ns/1ps
module qtc_pin_model (
  input wire logic clk,
  output logic evt,
  output logic [1:0] cap
);
  initial begin
    evt = 1'b0;
    cap = 2'h0;
  end
  // each level held four cycles so the synchroniser sees it
  task automatic ev(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      evt <= 1'b1;
      repeat (4) @(posedge clk);
      evt <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse(input int b);
    repeat (4) @(posedge clk);
    cap[b] <= 1'b1;
    repeat (4) @(posedge clk);
    cap[b] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // qtc_pin_model

// file: tb/qtc_tb_top.sv
// bench for the quad timer/counter: registers, event, capture and pin
`timescale 1ns/1ps
module qtc_tb_top;
  import qtc_pkg::*;
  typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] val;} qtc_row_t;
  logic CLOCK, RESETN, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic S_AXI_RREADY, EVENT_COUNT_INPUT, TIMER_OUT_PIN;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdv;
  logic [3:0] S_AXI_WSTRB, TIMER_MATCH_FLAG;
  logic [3:0] wstrb_v = 4'hF;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, CAPTURE_INPUT, rsp;
  int bad_count = 0;
  int num_checks = 0;
  qtc_row_t rows [22] = '{
    '{1'b0, 8'hD0, 8'h00}, '{1'b0, 8'hD1, 8'h00}, '{1'b0, 8'hD2, 8'h00},
    '{1'b0, 8'hD3, 8'h00}, '{1'b0, 8'hD4, 8'h00}, '{1'b0, 8'hD6, 8'h00},
    '{1'b0, 8'hD7, 8'h00}, '{1'b0, 8'hD8, 8'h00}, '{1'b0, 8'hDA, 8'h00},
    '{1'b0, 8'hDC, 8'h00}, '{1'b0, 8'hDD, 8'h05}, '{1'b1, 8'hD0, 8'hFF},
    '{1'b1, 8'hD2, 8'hFF}, '{1'b1, 8'hD6, 8'hFF}, '{1'b0, 8'hD0, 8'h3F},
    '{1'b0, 8'hD2, 8'h4F}, '{1'b0, 8'hD6, 8'h3F}, '{1'b1, 8'hD0, 8'h00},
    '{1'b1, 8'hD2, 8'h00}, '{1'b1, 8'hD6, 8'h00}, '{1'b1, 8'hD8, 8'hFF},
    '{1'b0, 8'hD8, 8'hEF}};

  qtc_top qtc_top_i (.*);
  qtc_pin_model qtc_pin_model_i (.clk(CLOCK), .evt(EVENT_COUNT_INPUT), .cap(CAPTURE_INPUT));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge CLOCK);
    S_AXI_AWADDR <= {2'h0, idx, 2'h0};
    S_AXI_WDATA <= {24'h00_0000, d};
    S_AXI_WSTRB <= wstrb_v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (aw && S_AXI_AWREADY) begin
        aw = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w && S_AXI_WREADY) begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end while (S_AXI_BVALID !== 1'b1);
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    logic ar;
    ar = 1'b1;
    @(posedge CLOCK);
    S_AXI_ARADDR <= {2'h0, idx, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ar && S_AXI_ARREADY) begin
        ar = 1'b0;
        S_AXI_ARVALID <= 1'b0;
      end
    end while (S_AXI_RVALID !== 1'b1);
    rdv = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(rdv, {24'h00_0000, exp});
  endtask
  task automatic complete_run;
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  initial begin
    #500_000;
    bad_count++;
    complete_run();
  end
  initial begin
    {RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    S_AXI_AWADDR = '0;
    S_AXI_ARADDR = '0;
    S_AXI_WDATA = '0;
    S_AXI_WSTRB = '0;
    repeat (12) @(posedge CLOCK);
    RESETN <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].idx, rows[i].val);
      end else begin
        rd_chk(rows[i].idx, rows[i].val);
      end
    end
    // a write with byte lane 0 disabled stores nothing but still answers
    wstrb_v = 4'hE;
    wr(8'hD2, 8'h4F);
    wstrb_v = 4'hF;
    chk(32'(rsp), 32'(RESP_OKAY));
    rd_chk(8'hD2, 8'h00);
    repeat (2) @(posedge CLOCK);
    chk(32'(TIMER_OUT_PIN), 32'h0000_0000);
    wr(8'hD8, 8'h20);
    repeat (2) @(posedge CLOCK);
    chk(32'(TIMER_OUT_PIN), 32'h0000_0001);
    wr(8'hD8, 8'h00);
    repeat (2) @(posedge CLOCK);
    chk(32'(TIMER_OUT_PIN), 32'h0000_0000);
    // event counting, pause, restart without clear, clear on start rise
    wr(8'hD0, 8'h1F);
    qtc_pin_model_i.ev(5);
    rd_chk(8'hD1, 8'h05);
    wr(8'hD0, 8'h1D);
    qtc_pin_model_i.ev(2);
    rd_chk(8'hD1, 8'h05);
    wr(8'hD0, 8'h1F);
    rd_chk(8'hD1, 8'h05);
    wr(8'hD0, 8'h1C);
    wr(8'hD0, 8'h1F);
    rd_chk(8'hD1, 8'h00);
    wr(8'hD1, 8'h03);
    qtc_pin_model_i.ev(4);
    rd_chk(8'hD1, 8'h00);
    chk(32'(TIMER_MATCH_FLAG), 32'h0000_0001);
    wr(8'hDC, 8'h01);
    chk(32'(TIMER_MATCH_FLAG), 32'h0000_0000);
    // capture on rising pin edge, then counter restarts from zero
    wr(8'hD1, 8'hFF);
    wr(8'hD0, 8'h3F);
    qtc_pin_model_i.ev(3);
    qtc_pin_model_i.pulse(0);
    rd_chk(8'hD1, 8'h03);
    wr(8'hD0, 8'h1F);
    rd_chk(8'hD1, 8'h00);
    // 16-bit pair: carry from the lower timer into the upper one
    wr(8'hD0, 8'h1C);
    wr(8'hD2, 8'h4F);
    wr(8'hD3, 8'hFF);
    wr(8'hD0, 8'h1F);
    qtc_pin_model_i.ev(257);
    rd_chk(8'hD1, 8'h01);
    rd_chk(8'hD4, 8'h01);
    chk(32'(TIMER_MATCH_FLAG), 32'h0000_0000);
    // timer 2 on the fastest prescaler tap reaches a compare of 1
    wr(8'hD0, 8'h1C);
    wr(8'hD7, 8'h01);
    wr(8'hD6, 8'h03);
    repeat (20) @(posedge CLOCK);
    chk(32'(TIMER_MATCH_FLAG), 32'h0000_0004);
    wr(8'hD6, 8'h00);
    // reset after the timers are stopped returns modes, counts and flags to zero
    RESETN <= 1'b0;
    repeat (3) @(posedge CLOCK);
    RESETN <= 1'b1;
    rd_chk(8'hD6, 8'h00);
    rd_chk(8'hD1, 8'h00);
    chk(32'(TIMER_MATCH_FLAG), 32'h0000_0000);
    // unmapped index answers with an error and no data
    wr(8'h00, 8'h12);
    chk(32'(rsp), 32'(RESP_SLVERR));
    rd(8'h00);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(rdv, 32'h0000_0000);
    complete_run();
  end
endmodule // qtc_tb_top
